// ### spi_regs_pkg.sv
// Purpose: Shared constants for the serial register link, both ends
// Assumes: SPI mode 0, one opcode byte then one data byte per frame
// Notes: Host-side offsets are byte addresses on its plain command port
`default_nettype none
package spi_regs_pkg;
    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OP_WR_PIN_CONTROL = 8'h82;
    localparam logic [7:0] OP_RD_PIN_CONTROL = 8'h84;
    localparam logic [7:0] OP_RD_PIN_STATE = 8'h86;
    localparam logic [7:0] OP_RD_MULTICHIP = 8'hB7;
    localparam logic [7:0] OP_WR_MULTICHIP = 8'hB8;

    // ************************************************************
    // Register layout and reset values
    // ************************************************************
    localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MULTICHIP_RESET = 8'h00;
    localparam int DIR_HI = 7;
    localparam int DIR_LO = 4;
    localparam int LVL_HI = 3;
    localparam int LVL_LO = 0;
    localparam int DELAY2_HI = 7;
    localparam int DELAY2_LO = 6;
    localparam int DELAY1_HI = 5;
    localparam int DELAY1_LO = 4;
    localparam int DISABLE_HI = 3;
    localparam int DISABLE_LO = 0;

    // ************************************************************
    // Frame shape
    // ************************************************************
    localparam logic [4:0] OPCODE_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    // ************************************************************
    // Host command port and timing
    // ************************************************************
    localparam logic [3:0] ADDR_CMD = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_RXDATA = 4'h8;
    localparam int STATUS_BUSY = 0;
    localparam int STATUS_DONE = 1;
    localparam int CLK_SYS_NS = 40;
    localparam int SCLK_HALF_NS = 160;
    localparam logic [3:0] SCLK_HALF =
        4'((SCLK_HALF_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
endpackage
`default_nettype wire

// ### spi_link_if.sv
// Purpose: Four-wire serial link between host and device
// Assumes: Only the device ever drives the return line
// Notes: Undriven return line reads low, as through a pull-down
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;

    // Resolved wire level seen by the host
    assign miso = miso_oe & miso_o;

    modport device
    (
        input sclk,
        input cs_n,
        input mosi,
        output miso_o,
        output miso_oe
    );

    modport host
    (
        output sclk,
        output cs_n,
        output mosi,
        input miso
    );
endinterface
`default_nettype wire

// ### spi_multichip_device.sv
// Purpose: Device end: pin control, pin state and multi-chip registers
// Assumes: Clocked only by the link clock, which stops between frames
// Notes: Frame logic is cleared by chip select, registers by rst_b only
//
// Contract
// - Read-pin-control opcode shifts pin control out
// - Chip select release ends output, line released
// - Control bits 7-4 set pin directions
// - Control bits 3-0 set pin output levels
// - Parallel interface overrides the general pins
// - Pin control write applied after last falling clock
// - Read-pin-state opcode shifts live state out
// - State byte: pins, hold, protect, lock, move
// - Read-multichip opcode shifts multichip register out
// - Bits 7-6, 5-4 select memory read delays
// - Bits 3-0 block register access per chip
// - Multichip register itself is never blocked
// - Multichip write applied after last falling clock
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module spi_multichip_device
    import spi_regs_pkg::*;
(
    // Link
    spi_link_if.device link,
    input wire logic rst_b,
    // General pins
    input wire logic [3:0] general_pins_upper_in,
    output logic [3:0] general_pins_upper_out,
    output logic [3:0] general_pins_upper_oe,
    // Parallel interface claim on the general pins
    input wire logic parallel_active,
    input wire logic [3:0] parallel_pin_out,
    input wire logic [3:0] parallel_pin_oe,
    // Status sources
    input wire logic hold_pin_n,
    input wire logic write_protect_pin_n,
    input wire logic pll_lock,
    input wire logic block_move_active,
    input wire logic [1:0] chip_index,
    // Multi-chip settings
    output logic [1:0] second_memory_read_delay,
    output logic [1:0] first_memory_read_delay,
    output logic [3:0] register_access_disable_bits
);

    // ************************************************************
    // State
    // ************************************************************
    // Rising-edge frame state, cleared whenever chip select is high
    typedef struct packed {
        logic [9:0] sync1;
        logic [9:0] sync2;
        logic [4:0] cnt;
        logic [7:0] shreg;
        logic [7:0] opcode;
        logic [7:0] tx;
        logic drive;
        logic pend_pin;
        logic pend_mc;
    } frame_s;

    // Falling-edge output stage, also cleared by chip select
    typedef struct packed {
        logic miso;
        logic oe;
    } out_s;

    // Falling-edge registers, kept across frames
    typedef struct packed {
        logic [7:0] pin_control;
        logic [7:0] multichip_control;
    } regs_s;

    frame_s f;
    frame_s next_f;
    out_s o;
    out_s next_o;
    regs_s r;
    regs_s next_r;
    logic frame_rst_b;
    logic [7:0] op_now;
    logic [1:0] chip_sync;
    logic reg_ok;

    // Chip select doubles as the frame reset; the clock may never tick
    // after the last bit, so the frame cannot end on its own edges
    assign frame_rst_b = rst_b & ~link.cs_n;
    assign op_now = {f.shreg[6:0], link.mosi};
    assign chip_sync = f.sync2[1:0];
    assign reg_ok = ~r.multichip_control[chip_sync];

    // ************************************************************
    // Rising edge: sample input, decode opcode, stage writes
    // ************************************************************
    always_comb
    begin
        next_f = f;
        next_f.sync1 = {general_pins_upper_in, hold_pin_n,
            write_protect_pin_n, pll_lock, block_move_active, chip_index};
        next_f.sync2 = f.sync1;
        if (f.cnt != FRAME_BITS)
        begin
            next_f.cnt = f.cnt + 5'h01;
            next_f.shreg = op_now;
        end
        if (f.cnt == OPCODE_BITS - 5'h01)
        begin
            next_f.opcode = op_now;
            next_f.tx = 8'h00;
            next_f.drive = 1'b0;
            unique case (op_now)
                OP_RD_PIN_CONTROL:
                begin
                    next_f.tx = r.pin_control;
                    next_f.drive = reg_ok;
                end
                OP_RD_PIN_STATE:
                begin
                    // Pins 7-4, hold, protect, lock, move
                    next_f.tx = f.sync2[9:2];
                    next_f.drive = reg_ok;
                end
                OP_RD_MULTICHIP:
                begin
                    next_f.tx = r.multichip_control;
                    next_f.drive = 1'b1;
                end
                default:
                begin
                    next_f.drive = 1'b0;
                end
            endcase
        end
        if (f.cnt == FRAME_BITS - 5'h01)
        begin
            next_f.pend_pin = (f.opcode == OP_WR_PIN_CONTROL) && reg_ok;
            next_f.pend_mc = (f.opcode == OP_WR_MULTICHIP);
        end
    end

    always_ff @(posedge link.sclk or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
        begin
            f <= '0;
        end
        else
        begin
            f <= next_f;
        end
    end

    // ************************************************************
    // Falling edge: shift out and commit writes
    // ************************************************************
    always_comb
    begin
        next_o = o;
        // cnt 8..15 maps to bits 7..0; low bits inverted give that index
        next_o.miso = (f.cnt == FRAME_BITS) ? 1'b0 : f.tx[~f.cnt[2:0]];
        next_o.oe = f.drive && (f.cnt >= OPCODE_BITS);
    end

    always_ff @(negedge link.sclk or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
        begin
            o <= '0;
        end
        else
        begin
            o <= next_o;
        end
    end

    // Rewriting the same byte on later falling edges is harmless
    always_comb
    begin
        next_r = r;
        if (f.pend_pin)
        begin
            next_r.pin_control = f.shreg;
        end
        if (f.pend_mc)
        begin
            next_r.multichip_control = f.shreg;
        end
    end

    always_ff @(negedge link.sclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r <= '{pin_control: PIN_CONTROL_RESET,
                multichip_control: MULTICHIP_RESET};
        end
        else
        begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.miso_o = o.miso;
    // Gated by chip select so release does not wait for a clock
    assign link.miso_oe = o.oe & ~link.cs_n;

    always_comb
    begin
        if (parallel_active)
        begin
            general_pins_upper_out = parallel_pin_out;
            general_pins_upper_oe = parallel_pin_oe;
        end
        else
        begin
            general_pins_upper_out =
                r.pin_control[LVL_HI:LVL_LO];
            general_pins_upper_oe =
                r.pin_control[DIR_HI:DIR_LO];
        end
    end

    assign second_memory_read_delay =
        r.multichip_control[DELAY2_HI:DELAY2_LO];
    assign first_memory_read_delay =
        r.multichip_control[DELAY1_HI:DELAY1_LO];
    assign register_access_disable_bits =
        r.multichip_control[DISABLE_HI:DISABLE_LO];
endmodule
`default_nettype wire

// ### spi_multichip_host.sv
// Purpose: Host end: runs one 16-bit mode 0 frame per command
// Assumes: Software reads status before issuing the next command
// Notes: Link clock is divided from clk_sys and idles low
`timescale 1ns/10ps
`default_nettype none
module spi_multichip_host
    import spi_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Command port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Link
    spi_link_if.host link
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_LOW = 4'b0010,
        H_HIGH = 4'b0100,
        H_TAIL = 4'b1000
    } host_state_e;

    typedef struct packed {
        host_state_e st;
        logic [3:0] div;
        logic [4:0] bits;
        logic [15:0] tx;
        logic [7:0] rx;
        logic sclk;
        logic cs_n;
        logic done;
        logic miso_s1;
        logic miso_s2;
        logic [15:0] rdata;
    } host_s;

    host_s s;
    host_s next_s;
    logic busy;
    logic half_up;

    assign busy = (s.st != H_IDLE);
    assign half_up = (s.div == SCLK_HALF - 4'h1);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_s = s;
        next_s.miso_s1 = link.miso;
        next_s.miso_s2 = s.miso_s1;
        next_s.rdata = 16'h0000;
        if (rd)
        begin
            unique case (addr)
                ADDR_STATUS:
                begin
                    next_s.rdata[STATUS_BUSY] = busy;
                    next_s.rdata[STATUS_DONE] = s.done;
                    next_s.done = 1'b0;
                end
                ADDR_RXDATA:
                begin
                    next_s.rdata = {8'h00, s.rx};
                end
                default:
                begin
                    next_s.rdata = 16'h0000;
                end
            endcase
        end
        next_s.div = half_up ? 4'h0 : s.div + 4'h1;
        unique case (s.st)
            H_IDLE:
            begin
                next_s.div = 4'h0;
                // Commands while busy are dropped
                if (wr && addr == ADDR_CMD)
                begin
                    next_s.tx = wdata;
                    next_s.bits = 5'h00;
                    next_s.cs_n = 1'b0;
                    next_s.st = H_LOW;
                end
            end
            H_LOW:
            begin
                if (half_up)
                begin
                    next_s.sclk = 1'b1;
                    // Sampled two cycles late; half period covers it
                    next_s.rx = {s.rx[6:0], s.miso_s2};
                    next_s.st = H_HIGH;
                end
            end
            H_HIGH:
            begin
                if (half_up)
                begin
                    next_s.sclk = 1'b0;
                    next_s.tx = {s.tx[14:0], 1'b0};
                    next_s.bits = s.bits + 5'h01;
                    next_s.st = (s.bits == FRAME_BITS - 5'h01) ?
                        H_TAIL : H_LOW;
                end
            end
            H_TAIL:
            begin
                if (half_up)
                begin
                    // Last byte in rx is the answer of a read opcode
                    next_s.cs_n = 1'b1;
                    next_s.done = 1'b1;
                    next_s.st = H_IDLE;
                end
            end
            default:
            begin
                next_s.st = H_IDLE;
                next_s.cs_n = 1'b1;
                next_s.sclk = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s <= '{st: H_IDLE, div: 4'h0, bits: 5'h00, tx: 16'h0000,
                rx: 8'h00, sclk: 1'b0, cs_n: 1'b1, done: 1'b0,
                miso_s1: 1'b0, miso_s2: 1'b0, rdata: 16'h0000};
        end
        else
        begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.sclk = s.sclk;
    assign link.cs_n = s.cs_n;
    assign link.mosi = s.tx[15];
    assign rdata = s.rdata;
endmodule
`default_nettype wire

// ### spi_link_sva.sv
// Purpose: Link checks between the host end and the device end
// Assumes: Host divides the link clock from clk_sys
// Notes: Link signals are sampled on clk_sys; bits counted in helper logic
`timescale 1ns/10ps
`default_nettype none
module spi_link_sva
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso
);
    logic sclk_q;
    logic [4:0] rises;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ************************************************************
    // Rising link edges seen in the current frame
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_q <= 1'h0;
            rises <= 5'h00;
        end
        else
        begin
            sclk_q <= sclk;
            if (cs_n)
                rises <= 5'h00;
            else if (sclk && !sclk_q)
                rises <= rises + 5'h01;
        end
    end

    // ************************************************************
    // Frame shape
    // ************************************************************
    sequence lead_in;
        (!cs_n && !sclk) [*4] ##1 sclk;
    endsequence

    sequence high_phase;
        sclk [*4] ##1 !sclk;
    endsequence

    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("link clock runs outside a frame");
    frame_lead_a: assert property ($fell(cs_n) |-> lead_in)
        else $error("first link edge not four cycles after select");
    sclk_high_a: assert property ($rose(sclk) |-> high_phase)
        else $error("link clock high phase has wrong length");
    mosi_hold_a: assert property
        ((sclk && $past(sclk)) |-> $stable(mosi))
        else $error("host data moved while link clock high");
    miso_hold_a: assert property
        ((sclk && $past(sclk)) |-> $stable(miso_o))
        else $error("device data moved while link clock high");
    answer_start_a: assert property
        ($rose(miso_oe) |-> $fell(sclk) && rises == 5'h08)
        else $error("answer drive did not start after the opcode");
    // Drive is only legal from the answer byte until deselect
    line_release_a: assert property
        ((cs_n || rises < 5'h08) |-> !miso_oe)
        else $error("return line driven outside the answer byte");
    frame_len_a: assert property ($rose(cs_n) |-> rises == 5'h10)
        else $error("frame did not hold sixteen link edges");
    frame_end_a: assert property
        (($fell(sclk) && rises == 5'h10) |-> ##[1:8] cs_n)
        else $error("select not released after the last bit");
    idle_line_a: assert property (!miso_oe |-> !miso)
        else $error("released return line does not read low");
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: Drives host commands and checks both link ends
// Assumes: One frame at a time, status polled until done
// Notes: Table rows first, then override, blocking and reset cases
`timescale 1ns/10ps
`default_nettype none
`define check(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("unexpected at %0t: got %h expected %h", \
                $time, (got), (exp)); \
        end \
    end
module testbench;
    import spi_regs_pkg::*;
    typedef struct packed
    {
        logic [7:0] op;
        logic [7:0] d;
        logic [7:0] st;
        logic [7:0] rx;
        logic [7:0] pins;
        logic [7:0] mc;
    } row_s;
    logic clk_sys;
    logic rst_b;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic [3:0] pins_in;
    logic [3:0] pins_out;
    logic [3:0] pins_oe;
    logic par_act;
    logic [3:0] par_out;
    logic [3:0] par_oe;
    logic [3:0] flags;
    logic [1:0] chip;
    logic [1:0] delay2;
    logic [1:0] delay1;
    logic [3:0] dis;
    logic [7:0] rx;
    logic [15:0] word;
    int errors;
    int num_checks;
    row_s rows [8];

    spi_link_if link();
    spi_multichip_host i_spi_multichip_host (.clk_sys(clk_sys),
        .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link(link));
    spi_multichip_device i_spi_multichip_device (.link(link),
        .rst_b(rst_b), .general_pins_upper_in(pins_in),
        .general_pins_upper_out(pins_out), .general_pins_upper_oe(pins_oe),
        .parallel_active(par_act), .parallel_pin_out(par_out),
        .parallel_pin_oe(par_oe), .hold_pin_n(flags[3]),
        .write_protect_pin_n(flags[2]), .pll_lock(flags[1]),
        .block_move_active(flags[0]), .chip_index(chip),
        .second_memory_read_delay(delay2),
        .first_memory_read_delay(delay1),
        .register_access_disable_bits(dis));
    spi_link_sva i_spi_link_sva (.clk_sys(clk_sys), .rst_b(rst_b),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
        .miso_o(link.miso_o), .miso_oe(link.miso_oe), .miso(link.miso));

    // ************************************************************
    // Command port tasks
    // ************************************************************
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk_sys);
        wr <= 1'h0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk_sys);
        rd <= 1'h0;
        @(posedge clk_sys);
        d = rdata;
    endtask

    // One whole frame; gives back the byte received
    task automatic frame(input logic [7:0] op, input logic [7:0] d,
        output logic [7:0] b);
        logic [15:0] w;
        int n;
        bus_wr(ADDR_CMD, {op, d});
        w = 16'h0000;
        n = 0;
        while (w[STATUS_DONE] !== 1'h1 && n < 200)
        begin
            bus_rd(ADDR_STATUS, w);
            n++;
        end
        `check(w[STATUS_DONE], 1'h1)
        bus_rd(ADDR_RXDATA, w);
        b = w[7:0];
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Generous: the whole run needs about 2400 cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        test_done();
    end

    initial
    begin
        rst_b = 1'h0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'h0;
        rd = 1'h0;
        {pins_in, flags} = 8'h00;
        par_act = 1'h0;
        par_out = 4'h3;
        par_oe = 4'hC;
        chip = 2'h2;
        errors = 0;
        num_checks = 0;
        rows = '{'{OP_RD_PIN_CONTROL, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
            '{OP_WR_PIN_CONTROL, 8'hA5, 8'h00, 8'h00, 8'hA5, 8'h00},
            '{OP_RD_PIN_CONTROL, 8'h00, 8'h00, 8'hA5, 8'hA5, 8'h00},
            '{OP_RD_PIN_STATE, 8'h00, 8'h96, 8'h96, 8'hA5, 8'h00},
            '{OP_RD_PIN_STATE, 8'h00, 8'h69, 8'h69, 8'hA5, 8'h00},
            '{OP_WR_MULTICHIP, 8'h6B, 8'h00, 8'h00, 8'hA5, 8'h6B},
            '{OP_RD_MULTICHIP, 8'h00, 8'h00, 8'h6B, 8'hA5, 8'h6B},
            '{8'h05, 8'hFF, 8'h00, 8'h00, 8'hA5, 8'h6B}};
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'h1;
        @(posedge clk_sys);
        foreach (rows[i])
        begin
            {pins_in, flags} <= rows[i].st;
            frame(rows[i].op, rows[i].d, rx);
            `check(rx, rows[i].rx)
            `check({pins_oe, pins_out}, rows[i].pins)
            `check({delay2, delay1, dis}, rows[i].mc)
            `check(link.miso_oe, 1'h0)
            $display("row %0d done", i);
        end
        par_act <= 1'h1;
        repeat (2) @(posedge clk_sys);
        `check({pins_oe, pins_out}, 8'hC3)
        par_act <= 1'h0;
        repeat (2) @(posedge clk_sys);
        `check({pins_oe, pins_out}, 8'hA5)
        $display("parallel claim done");
        frame(OP_WR_MULTICHIP, 8'h04, rx);
        frame(OP_WR_PIN_CONTROL, 8'hFF, rx);
        `check({pins_oe, pins_out}, 8'hA5)
        frame(OP_RD_PIN_CONTROL, 8'h00, rx);
        `check(rx, 8'h00)
        {pins_in, flags} <= 8'hFF;
        frame(OP_RD_PIN_STATE, 8'h00, rx);
        `check(rx, 8'h00)
        frame(OP_RD_MULTICHIP, 8'h00, rx);
        `check(rx, 8'h04)
        // Another chip index is not blocked by the bit of index two
        chip <= 2'h1;
        frame(OP_RD_PIN_CONTROL, 8'h00, rx);
        `check(rx, 8'hA5)
        chip <= 2'h2;
        frame(OP_WR_MULTICHIP, 8'h00, rx);
        `check(dis, 4'h0)
        frame(OP_RD_PIN_STATE, 8'h00, rx);
        `check(rx, 8'hFF)
        bus_rd(4'hC, word);
        `check(word, 16'h0000)
        $display("access blocking done");
        rst_b <= 1'h0;
        repeat (2) @(posedge clk_sys);
        `check({pins_oe, pins_out, delay2, delay1, dis}, 16'h0000)
        `check(link.cs_n, 1'h1)
        rst_b <= 1'h1;
        @(posedge clk_sys);
        frame(OP_RD_PIN_CONTROL, 8'h00, rx);
        `check(rx, PIN_CONTROL_RESET)
        $display("reset done");
        test_done();
    end
endmodule
`default_nettype wire
